/* verilog/adc_mode_ctrl.sv */
/*
 * mode control and serial shift logic of a two-channel sampling converter,
 * plus the result fifo between the converter core and the shifter.
 * assumes the host drives chip select, serial clock and serial input,
 * all asynchronous to clock_i and slow enough for two-flop sampling.
 */
`timescale 1ns/100ps

module word_fifo #(
    parameter int W = 12,
    parameter int DEPTH = 16
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic [W-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [W-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic rdy;
    } fifo_t;
    fifo_t r;
    fifo_t n;
    logic push;
    logic pop;

    always_comb begin
        n = r;
        push = in_valid_i && r.rdy;
        pop = out_ready_i && (r.cnt != '0);
        if (push) begin
            n.mem[r.wp] = in_data_i;
            n.wp = r.wp + 1'b1;
        end
        if (pop) begin
            n.rp = r.rp + 1'b1;
        end
        n.cnt = r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        // ready registered from the next count, so a full fifo stalls the core on the edge that fills it
        n.rdy = (n.cnt != (AW+1)'(DEPTH));
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r <= '{mem: '0, wp: '0, rp: '0, cnt: '0, rdy: 1'b1};
        end else begin
            r <= n;
        end
    end

    assign in_ready_o = r.rdy;
    assign out_data_o = r.mem[r.rp];
    assign out_valid_o = (r.cnt != '0);
endmodule // word_fifo

module adc_mode_ctrl
    import adc_ctrl_pkg::*;
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic din_i,
    input wire logic [RES_BITS-1:0] result_i,
    input wire logic result_valid_i,
    output logic result_ready_o,
    output logic dout_o,
    output logic dout_oe_o,
    output logic track_o,
    output logic powered_o,
    output logic word_ok_o,
    output logic [1:0] mode_o
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [2:0] cs_p;
        logic [2:0] ck_p;
        logic [1:0] di_p;
        mode_t mode;
        logic active;
        logic [CNT_W-1:0] cnt;
        logic [WORD_BITS-1:0] shreg;
        logic chn_cap;
        logic sty_cap;
        logic chn_next;
        logic [PU_W-1:0] puc;
        logic dout;
        logic oe;
        logic track;
        logic powered;
        logic word_ok;
    } state_t;
    state_t r;
    state_t n;
    logic cs_fall;
    logic cs_rise;
    logic ck_fall;
    logic ck_rise;
    logic din_s;
    logic [RES_BITS-1:0] f_data;
    logic f_valid;
    logic f_pop;
    logic f_ready;
    logic [CNT_W-1:0] cnt_inc;

    word_fifo #(.W(RES_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .in_data_i(result_i),
        .in_valid_i(result_valid_i),
        .in_ready_o(f_ready),
        .out_data_o(f_data),
        .out_valid_o(f_valid),
        .out_ready_i(f_pop)
    );

    // stage 0 of each pipe is the metastable flop, read only by stage 1
    assign cs_fall = r.cs_p[2] && !r.cs_p[1];
    assign cs_rise = !r.cs_p[2] && r.cs_p[1];
    assign ck_fall = r.ck_p[2] && !r.ck_p[1] && r.active;
    assign ck_rise = !r.ck_p[2] && r.ck_p[1] && r.active;
    assign din_s = r.di_p[1];
    assign cnt_inc = (r.cnt == CNT_MAX) ? r.cnt : r.cnt + 1'b1;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        n = r;
        f_pop = 1'b0;
        n.cs_p = {r.cs_p[1:0], cs_n_i};
        n.ck_p = {r.ck_p[1:0], sclk_i};
        n.di_p = {r.di_p[0], din_i};
        n.powered = (r.mode != MODE_PDOWN) || (r.active && r.puc >= PU_W'(PU_CYC));
        if (r.active && r.mode == MODE_PDOWN && r.puc != '1) begin
            n.puc = r.puc + 1'b1;
        end
        if (cs_fall) begin
            n.active = 1'b1;
            n.cnt = '0;
            n.puc = '0;
            n.track = 1'b0;
            n.oe = 1'b1;
            if (r.mode == MODE_DAISY) begin
                n.dout = r.shreg[WORD_BITS-1];
            end else begin
                // result stored and sent; empty fifo gives a zero result
                n.shreg = {2'h0, r.chn_next, r.chn_next,
                           f_valid ? f_data : {RES_BITS{1'b0}}};
                n.dout = 1'b0;
                n.word_ok = 1'b1;
                f_pop = f_valid;
            end
        end else if (ck_fall) begin
            n.cnt = cnt_inc;
            if (cnt_inc == CHN_FALL) begin
                n.chn_cap = din_s;
            end
            if (cnt_inc == STY_FALL) begin
                n.sty_cap = din_s;
            end
            if (r.mode == MODE_DAISY) begin
                n.shreg = {r.shreg[WORD_BITS-2:0], din_s};
                n.dout = r.shreg[WORD_BITS-2];
            end else if (cnt_inc < WORD_END) begin
                n.dout = r.shreg[4'(WORD_END - 1'b1 - cnt_inc)];
            end
            if (r.mode == MODE_DAISY && r.cnt == '0) begin
                // mode bit sits one place up after this shift; flip it against the word's channel
                n.shreg[WORD_BITS-3] = !r.shreg[WORD_BITS-3];
            end
            if (cnt_inc == WORD_END) begin
                n.oe = 1'b0;
            end
            if (r.mode == MODE_PDOWN && cnt_inc == TRACK_FALL) begin
                n.track = 1'b1;
            end
        end else if (ck_rise && r.mode != MODE_PDOWN && r.cnt >= NORM_MIN) begin
            n.track = 1'b1;
        end
        if (cs_rise) begin
            n.active = 1'b0;
            n.cnt = '0;
            n.oe = 1'b0;
            if (r.cnt >= STY_FALL) begin
                n.chn_next = r.chn_cap;
            end
            case (r.mode)
                MODE_NORMAL: begin
                    if (r.cnt >= PD_MIN && r.cnt < DC_MIN) begin
                        n.mode = MODE_PDOWN;
                    end else if (r.cnt >= DC_MIN && r.cnt < NORM_MIN) begin
                        n.mode = MODE_DAISY;
                        n.word_ok = (r.cnt < DC_BAD);
                    end
                end
                MODE_PDOWN: begin
                    if (r.cnt >= NORM_MIN) begin
                        n.mode = MODE_NORMAL;
                    end else if (r.cnt >= DC_MIN) begin
                        n.mode = MODE_DAISY;
                        n.word_ok = (r.cnt < DC_BAD);
                    end
                end
                MODE_DAISY: begin
                    if (r.cnt >= PD_MIN && r.cnt < DC_MIN) begin
                        n.mode = MODE_PDOWN;
                    end else if (r.cnt >= DC_MIN && r.cnt < NORM_MIN) begin
                        n.mode = MODE_NORMAL;
                    end else if (r.cnt >= NORM_MIN && r.chn_cap == r.sty_cap) begin
                        n.mode = MODE_NORMAL;
                    end
                end
                default: begin
                    n.mode = RESET_MODE;
                end
            endcase
            n.track = (n.mode != MODE_PDOWN);
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r <= '{cs_p: 3'h7, ck_p: 3'h7, mode: RESET_MODE, default: '0};
        end else begin
            r <= n;
        end
    end

    assign result_ready_o = f_ready;
    assign dout_o = r.dout;
    assign dout_oe_o = r.oe;
    assign track_o = r.track;
    assign powered_o = r.powered;
    assign word_ok_o = r.word_ok;
    assign mode_o = r.mode;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    property p_cnt_clear;
        cs_fall |=> (r.cnt == '0) ##1 (r.cnt <= 5'h01);
    endproperty
    a_cnt_clear: assert property (p_cnt_clear) else $error("count not cleared");
    property p_track_pd;
        ck_fall && !cs_rise && r.mode == MODE_PDOWN && r.cnt == 5'h04 |=> track_o;
    endproperty
    a_track_pd: assert property (p_track_pd) else $error("no track at fifth edge");
    property p_hold;
        cs_fall |=> !track_o;
    endproperty
    a_hold: assert property (p_hold) else $error("no hold at select fall");
    property p_pdown;
        cs_rise && r.mode == MODE_NORMAL && r.cnt >= 5'h02 && r.cnt < 5'h0a
            |=> mode_o == MODE_PDOWN && !track_o;
    endproperty
    a_pdown: assert property (p_pdown) else $error("power-down missed");
    property p_daisy_in;
        cs_rise && r.mode != MODE_DAISY && r.cnt >= 5'h0a && r.cnt < 5'h0d
            |=> mode_o == MODE_DAISY && word_ok_o == ($past(r.cnt) < 5'h0c);
    endproperty
    a_daisy_in: assert property (p_daisy_in) else $error("daisy entry missed");
    property p_wake;
        cs_rise && r.mode == MODE_PDOWN && r.cnt >= 5'h0d |=> mode_o == MODE_NORMAL;
    endproperty
    a_wake: assert property (p_wake) else $error("wake to normal missed");
    property p_oe_off;
        cs_rise |=> !dout_oe_o [*2];
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("output still driven");
    property p_keep;
        cs_rise && r.mode == MODE_DAISY && r.cnt >= 5'h0d
            |=> (mode_o == MODE_DAISY) == ($past(r.chn_cap) != $past(r.sty_cap));
    endproperty
    a_keep: assert property (p_keep) else $error("daisy keep wrong");
    property p_exit;
        cs_rise && r.mode == MODE_DAISY && r.cnt >= 5'h0a && r.cnt < 5'h0d
            |=> mode_o == MODE_NORMAL;
    endproperty
    a_exit: assert property (p_exit) else $error("daisy exit missed");
    property p_shift;
        ck_fall && !cs_rise && r.mode == MODE_DAISY |=> dout_o == $past(r.shreg[14]);
    endproperty
    a_shift: assert property (p_shift) else $error("daisy shift wrong");
    c_daisy: cover property (cs_rise && r.mode == MODE_NORMAL && r.cnt == 5'h0b);
    c_wake: cover property (cs_rise && r.mode == MODE_PDOWN && r.cnt == 5'h10);
    c_full: cover property (!f_ready);
endmodule // adc_mode_ctrl

/* verilog/adc_ctrl_pkg.sv */
/*
 * constants and mode type shared by the converter mode control logic.
 * assumes a 100 MHz system clock sampling the serial pins.
 */
package adc_ctrl_pkg;
    // ****************************************
    // operating modes
    // ****************************************
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_DAISY = 2'h1,
        MODE_PDOWN = 2'h3
    } mode_t;
    // undefined at power application; power-down is the safe pick
    localparam mode_t RESET_MODE = MODE_PDOWN;
    // ****************************************
    // word layout and edge windows
    // ****************************************
    localparam int WORD_BITS = 16;
    localparam int RES_BITS = 12;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;
    localparam logic [CNT_W-1:0] CHN_FALL = 5'h03;
    localparam logic [CNT_W-1:0] STY_FALL = 5'h04;
    localparam logic [CNT_W-1:0] TRACK_FALL = 5'h05;
    localparam logic [CNT_W-1:0] PD_MIN = 5'h02;
    localparam logic [CNT_W-1:0] DC_MIN = 5'h0a;
    localparam logic [CNT_W-1:0] DC_BAD = 5'h0c;
    localparam logic [CNT_W-1:0] NORM_MIN = 5'h0d;
    localparam logic [CNT_W-1:0] WORD_END = 5'h10;
    localparam int FIFO_DEPTH = 16;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_NS = 10;
    localparam int POWERUP_NS = 1000;
    localparam int PU_CYC = (POWERUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int PU_W = 8;
endpackage

/* tb/host_model.sv */
/*
 * host model: drives chip select, serial clock and serial input of one converter.
 * assumes frames are issued one at a time by the bench through the frame task.
 */
`timescale 1ns/100ps
module host_model (
    output logic cs_n_o,
    output logic sclk_o,
    output logic din_o,
    input wire logic dout_i,
    input wire logic oe_i,
    input wire logic track_i
);
    // ****************************************
    // link timing
    // ****************************************
    localparam realtime HALF = 62.5;
    localparam realtime QUIET = 300.0;
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b1; // serial clock stands still between frames
        din_o = 1'b0;
    end
    // ****************************************
    // one frame of n falling edges
    // ****************************************
    task automatic frame(input int n, input logic [15:0] w, output logic [15:0] rd,
                         output logic [15:0] tk);
        rd = 16'h0000;
        tk = 16'h0000;
        cs_n_o = 1'b0;
        din_o = w[15];
        #HALF;
        for (int k = 1; k <= n; k++) begin
            rd[16-k] = oe_i ? dout_i : !dout_i; // undriven line shown inverted
            tk[16-k] = track_i;
            sclk_o = 1'b0;
            #HALF;
            sclk_o = 1'b1;
            if (k < 16) din_o = w[15-k];
            #HALF;
        end
        cs_n_o = 1'b1; // a half period past the last rise, a full period past the last fall, inside the window
        din_o = ~din_o; // released line has no pull, so it must not look held
        #QUIET;
    endtask
endmodule // host_model

/* tb/test_adc_mode_ctrl.sv */
/*
 * testbench of the converter mode control: mode table, serial words, fifo fill and drain,
 * reset in mid-run. assumes host_model.sv and the design package.
 */
`timescale 1ns/100ps
module test_adc_mode_ctrl;
    import adc_ctrl_pkg::*;
    typedef struct {int n; logic [15:0] din; mode_t mode; int wok;} row_t;
    localparam int LIMIT = 20000;
    logic clock_i, resetn_i, result_valid_i, result_ready_o, dout_o, dout_oe_o;
    logic track_o, powered_o, word_ok_o, channel_select_bit, chn_ok, echo_ok, held_ok;
    logic [11:0] result_i;
    logic [1:0] mode_o;
    logic [15:0] prev_din, held;
    wire logic cs_n, sclk, din;
    mode_t cur;
    int miscompares = 0, num_checks = 0, cycles = 0, pops = 0;
    // first row is the dummy cycle right after power
    row_t rows [15] = '{'{16, 16'h3000, MODE_NORMAL, -1}, '{16, 16'h0000, MODE_NORMAL, -1},
        '{1, 16'hffff, MODE_NORMAL, -1}, '{5, 16'h2000, MODE_PDOWN, -1},
        '{16, 16'h0000, MODE_NORMAL, -1}, '{11, 16'h1000, MODE_DAISY, 1},
        '{16, 16'ha5a5, MODE_DAISY, -1}, '{16, 16'h5a5a, MODE_DAISY, -1},
        '{16, 16'h3c3c, MODE_NORMAL, -1}, '{12, 16'h0000, MODE_DAISY, 0},
        '{11, 16'h2000, MODE_NORMAL, -1}, '{16, 16'h0000, MODE_NORMAL, -1},
        '{9, 16'h0000, MODE_PDOWN, -1}, '{9, 16'h0000, MODE_PDOWN, -1},
        '{13, 16'h0000, MODE_NORMAL, -1}};
    adc_mode_ctrl DUT (.clock_i(clock_i), .resetn_i(resetn_i), .cs_n_i(cs_n), .sclk_i(sclk),
        .din_i(din), .result_i(result_i), .result_valid_i(result_valid_i),
        .result_ready_o(result_ready_o), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
        .track_o(track_o), .powered_o(powered_o), .word_ok_o(word_ok_o), .mode_o(mode_o));
    host_model host (.cs_n_o(cs_n), .sclk_o(sclk), .din_o(din), .dout_i(dout_o),
        .oe_i(dout_oe_o), .track_i(track_o));
    // ****************************************
    // compares and closing
    // ****************************************
    task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_flag(input string what, input logic exp, input logic got);
        chk_word(what, {15'h0000, exp}, {15'h0000, got});
    endtask
    task automatic chk_mode(input mode_t exp, input logic [1:0] got);
        chk_word("mode", {14'h0000, exp}, {14'h0000, got});
    endtask
    task automatic report_and_stop;
        if (miscompares == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    function automatic logic [11:0] res_val(input int i);
        return {4'ha, i[7:0]};
    endfunction
    // ****************************************
    // one frame and its expectations
    // ****************************************
    task automatic run_row(input row_t r);
        logic [15:0] rd, tk;
        logic [11:0] res;
        res = (pops < 16) ? res_val(pops) : 12'h000; // empty fifo gives a zero result
        host.frame(r.n, r.din, rd, tk);
        if (cur != MODE_DAISY) begin
            held = {2'b00, channel_select_bit, channel_select_bit, res};
            if (r.n == 16 && chn_ok) chk_word("dout word", {2'b00, channel_select_bit, channel_select_bit, res}, rd);
            if (r.n == 16 && cur == MODE_PDOWN) chk_word("track", 16'h07ff, tk);
            if (r.n == 16 && cur == MODE_NORMAL) chk_word("track", 16'h0007, tk);
            pops++;
        end else if (echo_ok) begin
            // mode bit is rewritten in the chain, so it is masked out
            chk_word("daisy word", prev_din & 16'hefff, rd & 16'hefff);
        end else if (held_ok && r.n == 16) begin
            // first daisy read gives the stored result with the mode bit flipped
            chk_word("stored word", held ^ 16'h1000, rd);
        end
        held_ok = (cur != MODE_DAISY && chn_ok && r.wok == 1);
        echo_ok = (cur == MODE_DAISY && r.n == 16);
        prev_din = r.din;
        @(negedge clock_i);
        chk_mode(r.mode, mode_o);
        chk_flag("output enable", 1'b0, dout_oe_o);
        if (r.wok >= 0) chk_flag("word valid", r.wok[0], word_ok_o);
        if (r.mode != MODE_PDOWN) chk_flag("powered", 1'b1, powered_o);
        if (r.n >= 4) begin
            channel_select_bit = r.din[13];
            chn_ok = 1'b1;
        end
        cur = r.mode;
    endtask
    // ****************************************
    // clock, timeout, sequence
    // ****************************************
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        resetn_i = 1'b0;
        result_i = 12'h000;
        result_valid_i = 1'b0;
        channel_select_bit = 1'b0;
        chn_ok = 1'b0;
        echo_ok = 1'b0;
        held_ok = 1'b0;
        prev_din = 16'h0000;
        cur = RESET_MODE;
        repeat (8) @(negedge clock_i);
        resetn_i = 1'b1;
        for (int i = 0; i < 16; i++) begin
            result_i = res_val(i);
            result_valid_i = 1'b1;
            @(negedge clock_i);
        end
        chk_flag("fifo ready when full", 1'b0, result_ready_o);
        result_i = 12'hfff; // refused while full
        @(negedge clock_i);
        result_valid_i = 1'b0;
        foreach (rows[i]) run_row(rows[i]);
        while (pops < 17) run_row(row_t'{16, 16'h0000, MODE_NORMAL, -1});
        // reset again in mid-run, with the chain left in normal mode
        resetn_i = 1'b0;
        @(negedge clock_i);
        chk_mode(MODE_PDOWN, mode_o);
        chk_flag("track", 1'b0, track_o);
        chk_flag("output enable", 1'b0, dout_oe_o);
        chk_flag("powered", 1'b0, powered_o);
        chk_flag("word valid", 1'b0, word_ok_o);
        chk_flag("fifo ready", 1'b1, result_ready_o);
        resetn_i = 1'b1;
        // wake straight after release: hold until the fifth fall, empty fifo gives zero
        cur = RESET_MODE;
        echo_ok = 1'b0;
        run_row(row_t'{16, 16'h0000, MODE_NORMAL, -1});
        report_and_stop();
    end
endmodule // test_adc_mode_ctrl
